// file: design/sag_guard.sv
/*
 * Setpoint access guard: jumper and passcode gating of setting changes
 * per interface, idle timeout, and per-feature function decoding into
 * trip, auxiliary relay, reclose initiate, message and event outputs.
 * Assumes all inputs synchronous to SYS_CLK; change requests, code entries
 * and activity marks are one-cycle pulses from the panel and port handlers.
 */
// Decided for this implementation: the address-and-strobe port and the address map.
// Notes on behaviour
// - Panel change refused without jumper, error raised
// - Serial changes ignore the jumper
// - Stored eight-character passcode compared on entry
// - Passcode zero removes all passcode restriction
// - Nonzero passcode locks every interface until entered
// - Each interface keeps its own access enable
// - Panel command clears panel access
// - Wrong serial passcode clears that port's access
// - Thirty idle minutes clear an interface's access
// - Disabled feature does nothing; enabled operates
// - Trip drives trip relay, aux mask, message
// - Trip with reclose also pulses initiate
// - Alarm drives selected aux relays and message
// - Control drives selected aux relays only
// - Event logged for trip, reclose, alarm, control
// - Per-feature mask selects aux relays three-seven
// - Element compares measurement over or under pickup
// - Programmable delay before element output acts
// - Aux relays follow trip by five ms
// - Direction selection gates element by indication
`timescale 1ns/1ns
module sag_guard #(
   parameter logic [37:0] IDLE_CYCLES = sag_pkg::IDLE_CYCLES,
   parameter logic [16:0] MS_CYCLES   = sag_pkg::MS_CYCLES
) (
   // Clock and reset
   input  wire logic         SYS_CLK,
   input  wire logic         RST,
   // Register port
   input  wire logic [7:0]   ADDR,
   input  wire logic [31:0]  WDATA,
   input  wire logic         WR,
   input  wire logic         RD,
   output logic      [31:0]  RDATA,
   // Front panel
   input  wire logic         JUMPER,
   input  wire logic         PANEL_ACT,
   input  wire logic         PANEL_CODE_VLD,
   input  wire logic [63:0]  PANEL_CODE,
   input  wire logic         PANEL_CLR,
   input  wire logic         PANEL_CHG_REQ,
   output logic              PANEL_CHG_OK,
   output logic              PANEL_CHG_ERR,
   // Serial ports, port p in bit p or slice p; ACCESS_EN has the panel in bit 0 and port p in bit p+1
   input  wire logic [2:0]   SER_ACT,
   input  wire logic [2:0]   SER_CODE_WR,
   input  wire logic [191:0] SER_CODE,
   input  wire logic [2:0]   SER_CHG_REQ,
   output logic      [2:0]   SER_CHG_OK,
   output logic      [2:0]   SER_CHG_ERR,
   output logic      [3:0]   ACCESS_EN,
   // Feature inputs, feature f in slice f
   input  wire logic [63:0]  MEAS,
   input  wire logic [3:0]   DIR_FWD,
   input  wire logic [3:0]   DIR_REV,
   // Feature outputs
   output logic              TRIP_RELAY,
   output logic      [4:0]   AUX_RELAY,
   output logic      [3:0]   RECLOSE_INIT,
   output logic      [3:0]   TRIP_MSG,
   output logic      [3:0]   ALARM_MSG,
   output logic      [3:0]   EVENT_LOG
);
   typedef struct packed {
      logic [63:0]       code;
      logic [3:0]        acc;
      logic [3:0][37:0]  idle;
      logic              pan_ok;
      logic              pan_err;
      logic [2:0]        ser_ok;
      logic [2:0]        ser_err;
      logic [3:0][10:0]  cfg;
      logic [3:0][15:0]  pick;
      logic [3:0][15:0]  dly;
      logic [16:0]       pre;
      logic              tick;
      logic [3:0][15:0]  cnt;
      logic [3:0]        op;
      logic [3:0][2:0]   lag;
      logic [3:0]        aux_op;
      logic [3:0]        lat;
      logic              trip;
      logic [4:0]        aux;
      logic [3:0]        rinit;
      logic [3:0]        tmsg;
      logic [3:0]        amsg;
      logic [3:0]        evt;
      logic [31:0]       rdata;
   } sag_state_t;

   sag_state_t q;
   sag_state_t d;

   logic            code_zero;
   logic [3:0]      act;
   logic [3:0]      hit;
   logic [3:0]      miss;
   logic [3:0]      expire;
   logic [3:0]      raw;
   sag_pkg::sag_fn_t fn [4];

   // Zero passcode lifts all passcode restriction
   assign code_zero = (q.code == sag_pkg::CODE_ZERO);

   always_comb begin
      int i;
      logic [7:0] a;
      logic       trip_like;
      logic       drives;
      logic       dir_ok;
      logic       cmp;
      sag_pkg::sag_dir_t dr;
      i         = 0;
      d         = q;
      a         = ADDR;
      trip_like = 1'b0;
      drives    = 1'b0;
      dir_ok    = 1'b0;
      cmp       = 1'b0;
      dr        = sag_pkg::DIR_ANY;
      act       = {SER_ACT | SER_CODE_WR | SER_CHG_REQ,
                   PANEL_ACT | PANEL_CODE_VLD | PANEL_CHG_REQ | PANEL_CLR};
      hit       = 4'h0;
      miss      = 4'h0;
      expire    = 4'h0;
      raw       = 4'h0;

      // Register writes
      if (WR) begin
         if (a == sag_pkg::REG_CODE_LO) begin
            d.code[31:0] = WDATA;
         end
         if (a == sag_pkg::REG_CODE_HI) begin
            d.code[63:32] = WDATA;
         end
         for (i = 0; i < sag_pkg::NUM_FT; i++) begin
            if (a == sag_pkg::REG_CFG0 + 8'(4 * i)) begin
               d.cfg[i] = WDATA[10:0];
            end
            if (a == sag_pkg::REG_PICK0 + 8'(4 * i)) begin
               d.pick[i] = WDATA[15:0];
            end
            if (a == sag_pkg::REG_DLY0 + 8'(4 * i)) begin
               d.dly[i] = WDATA[15:0];
            end
         end
      end

      // Code entry outcome per interface; exact match only
      hit[0]  = PANEL_CODE_VLD && (PANEL_CODE == q.code);
      miss[0] = PANEL_CODE_VLD && (PANEL_CODE != q.code);
      for (i = 0; i < sag_pkg::NUM_SER; i++) begin
         hit[i+1]  = SER_CODE_WR[i] && (SER_CODE[i*64 +: 64] == q.code);
         miss[i+1] = SER_CODE_WR[i] && (SER_CODE[i*64 +: 64] != q.code);
      end

      // Access enables and idle timers, each interface on its own
      for (i = 0; i < sag_pkg::NUM_IF; i++) begin
         expire[i] = q.acc[i] && !act[i] && (q.idle[i] == IDLE_CYCLES - 38'h0_0000_0001);
         if (act[i] || !q.acc[i]) begin
            d.idle[i] = 38'h0_0000_0000;
         end else begin
            d.idle[i] = q.idle[i] + 38'h0_0000_0001;
         end
         if (expire[i] || miss[i]) begin
            d.acc[i] = 1'b0;
         end
         if (i == 0 && PANEL_CLR) begin
            d.acc[i] = 1'b0;
         end
         // Unlock wins over a clear landing in the same cycle
         if (hit[i]) begin
            d.acc[i] = 1'b1;
         end
      end

      // Change request answers, one cycle after the request
      d.pan_ok  = PANEL_CHG_REQ && JUMPER && (code_zero || q.acc[0]);
      d.pan_err = PANEL_CHG_REQ && !(JUMPER && (code_zero || q.acc[0]));
      for (i = 0; i < sag_pkg::NUM_SER; i++) begin
         // Jumper plays no part on serial ports
         d.ser_ok[i]  = SER_CHG_REQ[i] && (code_zero || q.acc[i+1]);
         d.ser_err[i] = SER_CHG_REQ[i] && !(code_zero || q.acc[i+1]);
      end

      // Millisecond tick shared by all delays
      d.tick = (q.pre == MS_CYCLES - 17'h0_0001);
      d.pre  = d.tick ? 17'h0_0000 : q.pre + 17'h0_0001;

      d.trip  = 1'b0;
      d.aux   = 5'h00;
      d.rinit = 4'h0;
      d.evt   = 4'h0;
      for (i = 0; i < sag_pkg::NUM_FT; i++) begin
         if (q.cfg[i][2:0] > 3'(sag_pkg::FN_CONTROL)) begin
            fn[i] = sag_pkg::FN_DISABLED;
         end else begin
            fn[i] = sag_pkg::sag_fn_t'(q.cfg[i][2:0]);
         end
         dr = sag_pkg::sag_dir_t'(q.cfg[i][sag_pkg::CFG_DR_LO +: 2]);
         unique case (dr)
            sag_pkg::DIR_ANY:     dir_ok = 1'b1;
            sag_pkg::DIR_FORWARD: dir_ok = DIR_FWD[i];
            sag_pkg::DIR_REVERSE: dir_ok = DIR_REV[i];
            default:              dir_ok = 1'b0;
         endcase
         if (q.cfg[i][sag_pkg::CFG_UNDER]) begin
            cmp = MEAS[i*16 +: 16] < q.pick[i];
         end else begin
            cmp = MEAS[i*16 +: 16] > q.pick[i];
         end
         raw[i] = cmp && dir_ok && (fn[i] != sag_pkg::FN_DISABLED);

         // Programmable delay from dly, in milliseconds, before the output acts
         if (!raw[i]) begin
            d.cnt[i] = 16'h0000;
         end else if (q.tick && q.cnt[i] < q.dly[i]) begin
            d.cnt[i] = q.cnt[i] + 16'h0001;
         end
         d.op[i] = raw[i] && (q.cnt[i] >= q.dly[i]);

         // Aux contacts trail the trip contact by a fixed lag
         if (!q.op[i]) begin
            d.lag[i] = 3'h0;
         end else if (q.tick && q.lag[i] < sag_pkg::AUX_LAG_MS) begin
            d.lag[i] = q.lag[i] + 3'h1;
         end
         d.aux_op[i] = q.op[i] && (q.lag[i] >= sag_pkg::AUX_LAG_MS);

         trip_like = (fn[i] == sag_pkg::FN_TRIP) ||
                     (fn[i] == sag_pkg::FN_TRIP_WITH_RECLOSE_INITIATE);
         drives    = trip_like || (fn[i] == sag_pkg::FN_ALARM) ||
                     (fn[i] == sag_pkg::FN_LATCHED_ALARM) || (fn[i] == sag_pkg::FN_CONTROL);
         if (trip_like && q.op[i]) begin
            d.trip = 1'b1;
         end
         if (drives && q.aux_op[i]) begin
            d.aux = d.aux | q.cfg[i][sag_pkg::CFG_AX_LO +: sag_pkg::NUM_AUX];
         end
         d.tmsg[i]  = trip_like && q.op[i];
         d.rinit[i] = (fn[i] == sag_pkg::FN_TRIP_WITH_RECLOSE_INITIATE)
                      && q.op[i] && !q.lat[i];
         // Latched alarm holds its message until cleared by software
         if (WR && a == sag_pkg::REG_LAT_CLR && WDATA[i]) begin
            d.amsg[i] = 1'b0;
         end else if (fn[i] != sag_pkg::FN_LATCHED_ALARM) begin
            d.amsg[i] = 1'b0;
         end
         if ((fn[i] == sag_pkg::FN_ALARM || fn[i] == sag_pkg::FN_LATCHED_ALARM) && q.op[i]) begin
            d.amsg[i] = 1'b1;
         end
         d.evt[i] = q.op[i] && !q.lat[i] && (trip_like || fn[i] == sag_pkg::FN_ALARM ||
                    fn[i] == sag_pkg::FN_CONTROL);
         d.lat[i] = q.op[i];
      end

      // Read data; passcode reads back as zero so it cannot be sniffed
      d.rdata = 32'h0000_0000;
      if (RD) begin
         if (a == sag_pkg::REG_STATUS) begin
            d.rdata = {26'h000_0000, !code_zero, JUMPER, q.acc};
         end
         if (a == sag_pkg::REG_OUTS) begin
            d.rdata = {14'h0000, q.amsg, q.tmsg, q.op, q.aux, q.trip};
         end
         for (i = 0; i < sag_pkg::NUM_FT; i++) begin
            if (a == sag_pkg::REG_CFG0 + 8'(4 * i)) begin
               d.rdata = {21'h00_0000, q.cfg[i]};
            end
            if (a == sag_pkg::REG_PICK0 + 8'(4 * i)) begin
               d.rdata = {16'h0000, q.pick[i]};
            end
            if (a == sag_pkg::REG_DLY0 + 8'(4 * i)) begin
               d.rdata = {16'h0000, q.dly[i]};
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         q         <= '0;
         q.code    <= sag_pkg::CODE_ZERO;
         q.cfg     <= {4{sag_pkg::CFG_RST}};
      end else begin
         q <= d;
      end
   end

   assign RDATA         = q.rdata;
   assign PANEL_CHG_OK  = q.pan_ok;
   assign PANEL_CHG_ERR = q.pan_err;
   assign SER_CHG_OK    = q.ser_ok;
   assign SER_CHG_ERR   = q.ser_err;
   assign ACCESS_EN     = q.acc;
   assign TRIP_RELAY    = q.trip;
   assign AUX_RELAY     = q.aux;
   assign RECLOSE_INIT  = q.rinit;
   assign TRIP_MSG      = q.tmsg;
   assign ALARM_MSG     = q.amsg;
   assign EVENT_LOG     = q.evt;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence panel_unlock_alone_s;
      hit[0] && (SER_CODE_WR == 3'h0) && (expire[3:1] == 3'h0);
   endsequence

   sequence f0_trip_op_s;
      (fn[0] == sag_pkg::FN_TRIP || fn[0] == sag_pkg::FN_TRIP_WITH_RECLOSE_INITIATE) && q.op[0];
   endsequence

   no_jumper_err_a: assert property (PANEL_CHG_REQ && !JUMPER |=> PANEL_CHG_ERR && !PANEL_CHG_OK)
      else $error("panel change accepted without jumper");
   serial_free_a: assert property (SER_CHG_REQ[0] && code_zero |=> SER_CHG_OK[0])
      else $error("serial change refused with zero passcode");
   locked_refuse_a: assert property (SER_CHG_REQ[1] && !code_zero && !q.acc[2] |=> SER_CHG_ERR[1])
      else $error("locked port accepted a change");
   unlock_isolated_a: assert property (panel_unlock_alone_s |=> ACCESS_EN[0] && ACCESS_EN[3:1] == $past(q.acc[3:1]))
      else $error("panel unlock disturbed other interfaces");
   panel_clear_a: assert property (PANEL_CLR && !PANEL_CODE_VLD |=> !ACCESS_EN[0])
      else $error("panel clear left access on");
   wrong_code_a: assert property (SER_CODE_WR[1] && SER_CODE[127:64] != q.code |=> !ACCESS_EN[2])
      else $error("wrong passcode left port access on");
   idle_expire_a: assert property (expire[3] && !hit[3] |=> !ACCESS_EN[3] ##1 (!ACCESS_EN[3] || $past(act[3])))
      else $error("idle port kept access");
   disabled_quiet_a: assert property (fn[0] == sag_pkg::FN_DISABLED |=> !TRIP_MSG[0] && !ALARM_MSG[0] && !EVENT_LOG[0])
      else $error("disabled feature produced output");
   trip_cause_a: assert property (f0_trip_op_s |=> TRIP_RELAY && TRIP_MSG[0])
      else $error("trip op without trip relay");
   reclose_pulse_a: assert property (RECLOSE_INIT[0] |=> !RECLOSE_INIT[0])
      else $error("reclose initiate longer than one cycle");
   control_silent_a: assert property (fn[0] == sag_pkg::FN_CONTROL |=> !TRIP_MSG[0] && !ALARM_MSG[0])
      else $error("control feature raised a message");
endmodule : sag_guard

// file: design/sag_pkg.sv
/*
 * Constants for the setpoint access guard: register map, field layout,
 * function and direction selections, and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit internal register port.
 */
package sag_pkg;
   // Interfaces: index 0 is the front panel, 1..3 the serial ports
   localparam int NUM_SER = 3;
   localparam int NUM_IF  = 4;
   localparam int NUM_FT  = 4;

   // Passcode of eight 8-bit characters, first character in the low byte
   localparam int          CODE_W    = 64;
   localparam logic [63:0] CODE_ZERO = 64'h0000_0000_0000_0030;

   // Timing
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          IDLE_MIN      = 30;
   localparam logic [63:0] IDLE_CYC_W    = 64'(IDLE_MIN) * 64'h0000_0000_0000_003c
                                           * 64'h0000_0000_3b9a_ca00 / 64'(CLK_PERIOD_NS);
   localparam logic [37:0] IDLE_CYCLES   = IDLE_CYC_W[37:0];
   localparam logic [31:0] MS_CYC_W      = 32'h000f_4240 / 32'(CLK_PERIOD_NS);
   localparam logic [16:0] MS_CYCLES     = MS_CYC_W[16:0];
   localparam logic [2:0]  AUX_LAG_MS    = 3'h5;

   // Register byte addresses
   localparam logic [7:0] REG_CODE_LO = 8'h00;
   localparam logic [7:0] REG_CODE_HI = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam logic [7:0] REG_LAT_CLR = 8'h0c;
   localparam logic [7:0] REG_CFG0    = 8'h10;
   localparam logic [7:0] REG_PICK0   = 8'h20;
   localparam logic [7:0] REG_DLY0    = 8'h30;
   localparam logic [7:0] REG_OUTS    = 8'h40;

   // Feature configuration fields
   localparam int CFG_W     = 11;
   localparam int CFG_FN_LO = 0;
   localparam int CFG_DR_LO = 3;
   localparam int CFG_AX_LO = 5;
   localparam int CFG_UNDER = 10;
   localparam int NUM_AUX   = 5;
   localparam logic [10:0] CFG_RST = 11'h000;

   typedef enum logic [2:0] {
      FN_DISABLED,
      FN_ENABLED,
      FN_TRIP,
      FN_TRIP_WITH_RECLOSE_INITIATE,
      FN_ALARM,
      FN_LATCHED_ALARM,
      FN_CONTROL
   } sag_fn_t;

   typedef enum logic [1:0] {
      DIR_ANY,
      DIR_FORWARD,
      DIR_REVERSE
   } sag_dir_t;
endpackage : sag_pkg

// file: sim/sag_guard_test.sv
/*
 * Self-checking bench for the setpoint access guard.
 * Assumes shortened counts: 10 cycles per ms tick, 50 idle cycles.
 */
`timescale 1ns/1ns
module sag_guard_test;
   typedef struct {
      string       what;
      logic [31:0] val;
   } sag_note_t;

   logic          SYS_CLK = 1'b0;
   logic          RST     = 1'b1;
   logic [7:0]    ADDR    = 8'h00;
   logic [31:0]   WDATA   = 32'h0000_0000;
   logic          WR      = 1'b0;
   logic          RD      = 1'b0;
   logic          JUMPER  = 1'b0;
   logic [63:0]   MEAS    = 64'h0000_0000_0000_0000;
   logic [3:0]    DIR_FWD = 4'h0;
   logic [3:0]    DIR_REV = 4'h0;
   logic [31:0]   RDATA;
   logic [63:0]   PANEL_CODE;
   logic [191:0]  SER_CODE;
   logic          PANEL_ACT, PANEL_CODE_VLD, PANEL_CLR, PANEL_CHG_REQ, PANEL_CHG_OK;
   logic          PANEL_CHG_ERR, TRIP_RELAY;
   logic [2:0]    SER_ACT, SER_CODE_WR, SER_CHG_REQ, SER_CHG_OK, SER_CHG_ERR;
   logic [3:0]    ACCESS_EN, RECLOSE_INIT, TRIP_MSG, ALARM_MSG, EVENT_LOG;
   logic [4:0]    AUX_RELAY;
   logic [7:0]    chg;
   logic          rd_q = 1'b0;
   logic [63:0]   code;
   sag_note_t     notes[$];
   sag_note_t     n;
   int            bad_count = 0;
   int            checks_done = 0;
   int            ev_cnt = 0;
   int            ri_cnt = 0;

   sag_guard #(.IDLE_CYCLES(38'h00_0000_0032), .MS_CYCLES(17'h0_000a)) dut (
      .SYS_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .JUMPER, .PANEL_ACT, .PANEL_CODE_VLD,
      .PANEL_CODE, .PANEL_CLR, .PANEL_CHG_REQ, .PANEL_CHG_OK, .PANEL_CHG_ERR, .SER_ACT,
      .SER_CODE_WR, .SER_CODE, .SER_CHG_REQ, .SER_CHG_OK, .SER_CHG_ERR, .ACCESS_EN, .MEAS,
      .DIR_FWD, .DIR_REV, .TRIP_RELAY, .AUX_RELAY, .RECLOSE_INIT, .TRIP_MSG, .ALARM_MSG,
      .EVENT_LOG);

   sag_ports_model m (
      .clk(SYS_CLK), .panel_act(PANEL_ACT), .panel_code_vld(PANEL_CODE_VLD),
      .panel_code(PANEL_CODE), .panel_clr(PANEL_CLR), .panel_chg_req(PANEL_CHG_REQ),
      .ser_act(SER_ACT), .ser_code_wr(SER_CODE_WR), .ser_code(SER_CODE),
      .ser_chg_req(SER_CHG_REQ));

   always #5 SYS_CLK = ~SYS_CLK;
   assign chg = {SER_CHG_ERR, SER_CHG_OK, PANEL_CHG_ERR, PANEL_CHG_OK};

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // Results arrive in request order, so the oldest note is the one due
   always @(posedge SYS_CLK) begin
      if (rd_q || chg != 8'h00) begin
         if (notes.size() == 0) check("unrequested result", 32'h0000_0000, 32'hffff_ffff);
         else begin
            n = notes.pop_front();
            check(n.what, n.val, rd_q ? RDATA : {24'h00_0000, chg});
         end
      end
      rd_q   <= RD;
      ev_cnt <= ev_cnt + int'(|EVENT_LOG);
      ri_cnt <= ri_cnt + int'(|RECLOSE_INIT);
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge SYS_CLK);
      WR    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      notes.push_back('{"rdata", e});
      @(posedge SYS_CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge SYS_CLK);
      RD   <= 1'b0;
   endtask : rd

   task automatic req(input int p, input bit ok);
      notes.push_back('{"change answer", ok ? 32'h0000_0001 << (p == 0 ? 0 : p + 1)
                                             : 32'h0000_0001 << (p == 0 ? 1 : p + 4)});
      m.change(p);
   endtask : req

   task automatic feat(input int f, input logic [2:0] fn, input logic [1:0] dir,
                       input logic under, input logic fwd, input logic rev);
      logic [4:0]  mask;
      logic [15:0] v;
      logic        op;
      logic        trp;
      logic        am;
      int          e0;
      int          r0;
      int          k;
      mask = 5'($urandom);
      v    = 16'($urandom_range(32'h0000_0fff)) + (under ? 16'h0000 : 16'h1001);
      op   = fn != 3'h0 && fn != 3'h7 &&
             (dir == 2'h0 || (dir == 2'h1 && fwd) || (dir == 2'h2 && rev));
      trp  = op && (fn == 3'h2 || fn == 3'h3);
      am   = op && (fn == 3'h4 || fn == 3'h5);
      wr(sag_pkg::REG_PICK0 + 8'(4 * f), 32'h0000_1000);
      wr(sag_pkg::REG_DLY0 + 8'(4 * f), 32'h0000_0002);
      wr(sag_pkg::REG_CFG0 + 8'(4 * f), {21'h00_0000, under, mask, dir, fn});
      e0 = ev_cnt;
      r0 = ri_cnt;
      DIR_FWD[f] <= fwd;
      DIR_REV[f] <= rev;
      MEAS[16*f +: 16] <= v;
      repeat (5) @(posedge SYS_CLK);
      rd(sag_pkg::REG_OUTS, 32'h0000_0000);
      if (trp) begin
         k = 0;
         while (TRIP_RELAY !== 1'b1 && k < 100) begin
            @(negedge SYS_CLK);
            k++;
         end
         if (k == 100) check("trip wait", 32'h0000_0001, 32'h0000_0000);
         check("aux lag", 32'h0000_0000, {27'h000_0000, AUX_RELAY});
      end
      repeat (120) @(posedge SYS_CLK);
      check("aux pins", 32'(op && fn >= 3'h2 ? mask : 5'h00), {27'h000_0000, AUX_RELAY});
      check("trip pin", 32'(trp), {31'h0000_0000, TRIP_RELAY});
      check("msg pins", (32'(trp) << f) | (32'(am) << (4 + f)),
            {24'h00_0000, ALARM_MSG, TRIP_MSG});
      rd(sag_pkg::REG_OUTS, 32'(trp) | (32'(op && fn >= 3'h2 ? mask : 5'h00) << 1)
         | (32'(op) << (6 + f)) | (32'(trp) << (10 + f)) | (32'(am) << (14 + f)));
      check("events", 32'(op && fn != 3'h5 && fn != 3'h1), 32'(ev_cnt - e0));
      check("reclose", 32'(op && fn == 3'h3), 32'(ri_cnt - r0));
      MEAS[16*f +: 16] <= under ? 16'hffff : 16'h0000;
      repeat (80) @(posedge SYS_CLK);
      rd(sag_pkg::REG_OUTS, 32'(am && fn == 3'h5) << (14 + f));
      wr(sag_pkg::REG_LAT_CLR, 32'h0000_0001 << f);
      wr(sag_pkg::REG_CFG0 + 8'(4 * f), 32'h0000_0000);
      DIR_FWD <= 4'h0;
      DIR_REV <= 4'h0;
   endtask : feat

   initial begin
      repeat (5) @(posedge SYS_CLK);
      RST <= 1'b0;
      void'($urandom(32'h6902_b06b));
      rd(sag_pkg::REG_STATUS, 32'h0000_0000);
      wr(8'hfc, $urandom);
      rd(8'hfc, 32'h0000_0000);
      req(0, 1'b0);
      for (int p = 1; p <= 3; p++) req(p, 1'b1);
      JUMPER <= 1'b1;
      req(0, 1'b1);
      $display("test open access done");
      code = {$urandom, $urandom} | 64'h0000_0000_0000_0100;
      wr(sag_pkg::REG_CODE_LO, code[31:0]);
      wr(sag_pkg::REG_CODE_HI, code[63:32]);
      rd(sag_pkg::REG_CODE_LO, 32'h0000_0000);
      rd(sag_pkg::REG_STATUS, 32'h0000_0030);
      req(0, 1'b0);
      req(1, 1'b0);
      m.code(2, code ^ 64'h0100_0000_0000_0000);
      rd(sag_pkg::REG_STATUS, 32'h0000_0030);
      m.code(2, code);
      rd(sag_pkg::REG_STATUS, 32'h0000_0034);
      req(2, 1'b1);
      req(1, 1'b0);
      m.code(0, code);
      req(0, 1'b1);
      JUMPER <= 1'b0;
      req(0, 1'b0);
      JUMPER <= 1'b1;
      m.clear();
      rd(sag_pkg::REG_STATUS, 32'h0000_0034);
      m.code(2, ~code);
      rd(sag_pkg::REG_STATUS, 32'h0000_0030);
      req(2, 1'b0);
      $display("test passcode locking done");
      m.code(3, code);
      repeat (30) @(posedge SYS_CLK);
      m.act(3);
      repeat (30) @(negedge SYS_CLK);
      check("idle hold", 32'h0000_0008, {28'h000_0000, ACCESS_EN});
      repeat (30) @(negedge SYS_CLK);
      check("idle clear", 32'h0000_0000, {28'h000_0000, ACCESS_EN});
      $display("test idle timeout done");
      for (int fn = 0; fn <= 7; fn++) feat(0, 3'(fn), 2'h0, 1'b0, 1'b0, 1'b0);
      feat(1, 3'h2, 2'h0, 1'b1, 1'b0, 1'b0);
      feat(2, 3'h6, 2'h1, 1'b0, 1'b1, 1'b0);
      feat(2, 3'h6, 2'h1, 1'b0, 1'b0, 1'b1);
      feat(2, 3'h6, 2'h3, 1'b0, 1'b1, 1'b1);
      feat(3, 3'h4, 2'h2, 1'b0, 1'b0, 1'b1);
      feat(3, 3'h4, 2'h2, 1'b0, 1'b1, 1'b0);
      $display("test feature outputs done");
      repeat (5) @(posedge SYS_CLK);
      check("results left over", 32'h0000_0000, 32'(notes.size()));
      results();
   end
endmodule : sag_guard_test

// file: sim/sag_ports_model.sv
/*
 * Front panel keypad and serial host model for the setpoint access guard.
 * Assumes its tasks are called one at a time from a single bench process.
 */
`timescale 1ns/1ns
module sag_ports_model (
   // Clock
   input  wire logic         clk,
   // Panel keypad
   output logic              panel_act,
   output logic              panel_code_vld,
   output logic      [63:0]  panel_code,
   output logic              panel_clr,
   output logic              panel_chg_req,
   // Serial hosts, port p in bit p or slice p
   output logic      [2:0]   ser_act,
   output logic      [2:0]   ser_code_wr,
   output logic      [191:0] ser_code,
   output logic      [2:0]   ser_chg_req
);
   initial begin
      {panel_act, panel_code_vld, panel_clr, panel_chg_req} = 4'h0;
      {ser_act, ser_code_wr, ser_chg_req} = 9'h000;
      panel_code = '0;
      ser_code   = '0;
   end

   // Interface p: 0 is the panel, 1..3 the serial ports
   task automatic act(input int p);
      @(posedge clk);
      if (p == 0) panel_act <= 1'b1;
      else ser_act[p-1] <= 1'b1;
      @(posedge clk);
      panel_act <= 1'b0;
      ser_act   <= 3'h0;
   endtask : act

   task automatic change(input int p);
      @(posedge clk);
      if (p == 0) panel_chg_req <= 1'b1;
      else ser_chg_req[p-1] <= 1'b1;
      @(posedge clk);
      panel_chg_req <= 1'b0;
      ser_chg_req   <= 3'h0;
   endtask : change

   // Operator closes panel access when done
   task automatic clear();
      @(posedge clk);
      panel_clr <= 1'b1;
      @(posedge clk);
      panel_clr <= 1'b0;
   endtask : clear

   // A wrong code to the unlocking register relocks that port
   task automatic code(input int p, input logic [63:0] c);
      @(posedge clk);
      if (p == 0) begin
         panel_code     <= c;
         panel_code_vld <= 1'b1;
      end else begin
         ser_code[64*(p-1) +: 64] <= c;
         ser_code_wr[p-1]         <= 1'b1;
      end
      @(posedge clk);
      panel_code_vld <= 1'b0;
      ser_code_wr    <= 3'h0;
      // Released data must not keep looking like the code
      panel_code     <= ~panel_code;
      ser_code       <= ~ser_code;
   endtask : code
endmodule : sag_ports_model
